// ### rtl/ude_dma_ctrl.sv
// Purpose: DMA request, acknowledge and end-of-transfer control for one endpoint
// Assumes: Endpoint buffers sit behind the ep_rx/ep_tx streams
// Notes: Pins pass two flops before use
// Function
// RULE1: Ack-only select bit chooses acknowledge-only mode, else separate-strobe mode.
// RULE2: In ack-only mode acknowledge is the data strobe; read/write strobes ignored.
// RULE3: Device raises request; controller acknowledges and may end via end_of_transfer.
// RULE4: Bulk ends on external eot, count, short packet, or enable cleared.
// RULE5: External eot on OUT stops DMA and discards current buffer data.
// RULE6: Eot on IN stops DMA and sends the held packet, even if short.
// RULE7: Sixteen-bit byte count; count termination only with counter eot enable.
// RULE8: Enable rise loads counter; completing the count ends the transfer.
// RULE9: Short-packet mode on OUT stops after the short packet's last byte.
// RULE10: On IN short-packet mode ends when count hits zero mid-buffer.
// RULE11: Clearing enable stops the transfer without an interrupt.
// RULE12: Iso ends on external eot, count, end-of-packet, or enable cleared.
// RULE13: Firmware should pick iso termination sources per direction as recommended.
// RULE14: Endpoint index 0010..1111 selects endpoint; direction bit gives read/write.
// RULE15: Request drops after each beat in single mode, after burst end in burst.
// RULE16: One DMA endpoint; acknowledge selects it regardless of register access.
// RULE17: After termination request stays low until enable is set again.
`timescale 1ns/10ps
module ude_fifo #(
    parameter int W = 10,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("ude_fifo depth: power of two >= 2");
    end
    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = cnt_r != FULL_CNT;
    assign out_valid = cnt_r != '0;
    assign out_data = mem_r[rd_ptr_r];
    always_ff @(posedge clk_sys) begin
        if (ce && push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end else if (ce) begin
            if (flush) begin
                wr_ptr_r <= '0;
                rd_ptr_r <= '0;
                cnt_r <= '0;
            end else begin
                if (push) begin
                    wr_ptr_r <= wr_ptr_r + 1'b1;
                end
                if (pop) begin
                    rd_ptr_r <= rd_ptr_r + 1'b1;
                end
                if (push && !pop) begin
                    cnt_r <= cnt_r + 1'b1;
                end else if (pop && !push) begin
                    cnt_r <= cnt_r - 1'b1;
                end
            end
        end
    end
endmodule : ude_fifo
module ude_dma_ctrl #(
    parameter int DEPTH = ude_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ce,
    input wire ude_pkg::ude_cfg_type cfg,
    input wire logic dma_enable,
    input wire logic [ude_pkg::CNT_W-1:0] byte_count,
    input wire logic dma_acknowledge,
    input wire logic end_of_transfer,
    input wire logic read_strobe,
    input wire logic write_strobe,
    input wire logic [ude_pkg::DATA_W-1:0] dma_data_in,
    output logic [ude_pkg::DATA_W-1:0] dma_data_out,
    output logic dma_data_oe,
    output logic dma_request,
    input wire logic ep_rx_valid,
    input wire ude_pkg::ude_beat_type ep_rx_beat,
    output logic ep_rx_ready,
    output logic ep_tx_valid,
    output ude_pkg::ude_beat_type ep_tx_beat,
    input wire logic ep_tx_ready,
    input wire logic usb_eop,
    output logic [3:0] dma_ep_select,
    output logic dma_ep_select_valid,
    output logic ep_discard,
    output logic ep_validate,
    output logic term_irq,
    output ude_pkg::ude_cause_type term_cause,
    output logic dma_active,
    output logic [ude_pkg::CNT_W-1:0] count_left
);
    localparam int BW = $bits(ude_pkg::ude_beat_type);
    if (DEPTH < 2) begin : g_bad_depth
        $error("ude_dma_ctrl depth < 2");
    end
    function automatic logic idx_ok(input logic [3:0] idx);
        return idx >= ude_pkg::EP_IDX_MIN && idx <= ude_pkg::EP_IDX_MAX;
    endfunction : idx_ok
    logic [ude_pkg::PIN_N-1:0] pin_s1_r;
    logic [ude_pkg::PIN_N-1:0] pin_s2_r;
    logic [ude_pkg::PIN_N-1:0] pin_prev_r;
    logic [ude_pkg::DATA_W-1:0] data_s1_r;
    logic [ude_pkg::DATA_W-1:0] data_s2_r;
    logic [ude_pkg::DATA_W-1:0] data_prev_r;
    logic [ude_pkg::PIN_N-1:0] pin_raw;
    logic [ude_pkg::PIN_N-1:0] pin_fall;
    logic [ude_pkg::PIN_N-1:0] pin_rise;
    assign pin_raw = {write_strobe, read_strobe, end_of_transfer, dma_acknowledge};
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_prev_r <= '0;
            data_s1_r <= '0;
            data_s2_r <= '0;
            data_prev_r <= '0;
        end else if (ce) begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
            data_s1_r <= dma_data_in;
            data_s2_r <= data_s1_r;
            data_prev_r <= data_s2_r;
        end
    end
    for (genvar gi = 0; gi < ude_pkg::PIN_N; gi++) begin : g_edge
        assign pin_rise[gi] = pin_s2_r[gi] && !pin_prev_r[gi];
        assign pin_fall[gi] = !pin_s2_r[gi] && pin_prev_r[gi];
    end
    ude_pkg::ude_state_type state_r;
    ude_pkg::ude_state_type state_nxt;
    ude_pkg::ude_cause_type cause_nxt;
    logic ack_lvl;
    logic strobe_lvl;
    logic xfer;
    logic active;
    logic en_prev_r;
    logic en_rise;
    logic hold_r;
    logic [ude_pkg::BURST_W-1:0] beat_r;
    logic [ude_pkg::CNT_W-1:0] cnt_r;
    logic [ude_pkg::PKT_W-1:0] pos_r;
    logic burst_end;
    logic term;
    logic fifo_flush;
    logic fifo_in_valid;
    ude_pkg::ude_beat_type fifo_in_data;
    logic fifo_in_ready;
    logic fifo_out_valid;
    ude_pkg::ude_beat_type fifo_out_data;
    logic fifo_out_ready;
    logic have_room;
    assign ack_lvl = pin_s2_r[ude_pkg::PIN_ACK];
    assign active = state_r == ude_pkg::ST_REQ || state_r == ude_pkg::ST_XFER;
    assign en_rise = dma_enable && !en_prev_r;
    // Ack-only mode: strobe is the acknowledge itself; beat completes on its release
    always_comb begin
        if (cfg.ack_only) begin // [RULE1]
            strobe_lvl = ack_lvl; // [RULE2]
            xfer = active && pin_fall[ude_pkg::PIN_ACK];
        end else if (cfg.dir_in) begin // [RULE14]
            strobe_lvl = ack_lvl && pin_s2_r[ude_pkg::PIN_WR];
            xfer = active && ack_lvl && pin_fall[ude_pkg::PIN_WR];
        end else begin
            strobe_lvl = ack_lvl && pin_s2_r[ude_pkg::PIN_RD];
            xfer = active && ack_lvl && pin_fall[ude_pkg::PIN_RD];
        end
    end
    // Bus data is taken from the cycle before the strobe fell, while still held
    assign fifo_in_valid = cfg.dir_in ? xfer : ep_rx_valid;
    assign fifo_in_data = cfg.dir_in ? ude_pkg::ude_beat_type'{short_pkt: 1'b0, last: 1'b0,
                                                               data: data_prev_r} : ep_rx_beat;
    assign ep_rx_ready = fifo_in_ready && !cfg.dir_in;
    assign fifo_out_ready = cfg.dir_in ? ep_tx_ready : xfer;
    assign ep_tx_valid = fifo_out_valid && cfg.dir_in;
    assign ep_tx_beat = fifo_out_data;
    assign have_room = cfg.dir_in ? fifo_in_ready : fifo_out_valid;
    ude_fifo #(.W(BW), .DEPTH(DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .ce(ce),
        .flush(fifo_flush),
        .in_valid(fifo_in_valid),
        .in_data(fifo_in_data),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_out_ready)
    );
    // Termination decode, disable first so no interrupt is raised for it
    always_comb begin
        cause_nxt = ude_pkg::CAUSE_NONE;
        if (active) begin
            if (!dma_enable) begin
                cause_nxt = ude_pkg::CAUSE_DISABLE; // [RULE4] [RULE11] [RULE12]
            end else if (pin_rise[ude_pkg::PIN_EOT]) begin
                cause_nxt = ude_pkg::CAUSE_EXT; // [RULE3] [RULE4] [RULE12]
            end else if (cfg.counter_eot_en && xfer && cnt_r == ude_pkg::CNT_LAST) begin
                cause_nxt = ude_pkg::CAUSE_COUNT; // [RULE7] [RULE8]
            end else if (!cfg.iso && cfg.short_eot_en && xfer && !cfg.dir_in
                         && fifo_out_data.last && fifo_out_data.short_pkt) begin
                cause_nxt = ude_pkg::CAUSE_SHORT; // [RULE9]
            end else if (!cfg.iso && cfg.short_eot_en && xfer && cfg.dir_in
                         && cnt_r == ude_pkg::CNT_LAST
                         && pos_r != cfg.max_pkt - 1'b1) begin
                cause_nxt = ude_pkg::CAUSE_SHORT; // [RULE10]
            end else if (cfg.iso && usb_eop) begin
                cause_nxt = ude_pkg::CAUSE_EOP; // [RULE12]
            end
        end
    end
    assign term = cause_nxt != ude_pkg::CAUSE_NONE;
    assign fifo_flush = ce && cause_nxt == ude_pkg::CAUSE_EXT && !cfg.dir_in; // [RULE5]
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ude_pkg::ST_IDLE: begin
                if (en_rise && idx_ok(cfg.ep_idx)) begin // [RULE14]
                    state_nxt = ude_pkg::ST_REQ;
                end
            end
            ude_pkg::ST_REQ: begin
                if (cause_nxt == ude_pkg::CAUSE_DISABLE) begin
                    state_nxt = ude_pkg::ST_IDLE;
                end else if (term) begin
                    state_nxt = ude_pkg::ST_DONE;
                end else if (ack_lvl) begin
                    state_nxt = ude_pkg::ST_XFER;
                end
            end
            ude_pkg::ST_XFER: begin
                if (cause_nxt == ude_pkg::CAUSE_DISABLE) begin
                    state_nxt = ude_pkg::ST_IDLE;
                end else if (term) begin
                    state_nxt = ude_pkg::ST_DONE;
                end else if (!ack_lvl) begin
                    state_nxt = ude_pkg::ST_REQ;
                end
            end
            ude_pkg::ST_DONE: begin
                if (!dma_enable) begin // [RULE17]
                    state_nxt = ude_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = ude_pkg::ST_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ude_pkg::ST_IDLE;
            en_prev_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            en_prev_r <= dma_enable;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= ude_pkg::CNT_RESET;
            pos_r <= '0;
        end else if (ce) begin
            if (en_rise) begin
                cnt_r <= byte_count; // [RULE8]
                pos_r <= '0;
            end else if (xfer) begin
                if (cnt_r != ude_pkg::CNT_RESET) begin
                    cnt_r <= cnt_r - ude_pkg::CNT_LAST;
                end
                pos_r <= (pos_r == cfg.max_pkt - 1'b1) ? '0 : pos_r + 1'b1;
            end
        end
    end
    // Request pacing; the hold clears only when acknowledge is released
    assign burst_end = !cfg.burst || beat_r == cfg.burst_len - 1'b1;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hold_r <= 1'b0;
            beat_r <= '0;
        end else if (ce) begin
            if (xfer && burst_end) begin
                hold_r <= 1'b1; // [RULE15]
                beat_r <= '0;
            end else if (xfer) begin
                beat_r <= beat_r + 1'b1;
            end else if (!ack_lvl) begin
                hold_r <= 1'b0;
            end
            if (!active) begin
                beat_r <= '0;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dma_request <= 1'b0;
        end else if (ce) begin
            dma_request <= !term && active && have_room && !hold_r
                           && !(xfer && burst_end)
                           && state_nxt != ude_pkg::ST_DONE; // [RULE3] [RULE15] [RULE17]
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dma_data_out <= '0;
            dma_data_oe <= 1'b0;
        end else if (ce) begin
            dma_data_out <= fifo_out_data.data;
            dma_data_oe <= active && !cfg.dir_in && strobe_lvl && fifo_out_valid;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dma_ep_select <= '0;
            dma_ep_select_valid <= 1'b0;
        end else if (ce) begin
            dma_ep_select <= cfg.ep_idx; // [RULE16]
            dma_ep_select_valid <= ack_lvl && idx_ok(cfg.ep_idx);
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ep_discard <= 1'b0;
            ep_validate <= 1'b0;
            term_irq <= 1'b0;
            term_cause <= ude_pkg::CAUSE_NONE;
            dma_active <= 1'b0;
            count_left <= ude_pkg::CNT_RESET;
        end else if (ce) begin
            ep_discard <= cause_nxt == ude_pkg::CAUSE_EXT && !cfg.dir_in; // [RULE5]
            ep_validate <= term && cause_nxt != ude_pkg::CAUSE_DISABLE
                           && cfg.dir_in; // [RULE6]
            term_irq <= term && cause_nxt != ude_pkg::CAUSE_DISABLE; // [RULE11]
            if (term) begin
                term_cause <= cause_nxt;
            end else if (en_rise) begin
                term_cause <= ude_pkg::CAUSE_NONE;
            end
            dma_active <= state_nxt == ude_pkg::ST_REQ || state_nxt == ude_pkg::ST_XFER;
            count_left <= cnt_r;
        end
    end
endmodule : ude_dma_ctrl

// ### rtl/ude_pkg.sv
// Purpose: Shared constants and types for the endpoint DMA transfer control
// Assumes: Byte-wide DMA data bus, one clock domain
// Notes: Pin inputs are active high at this boundary
package ude_pkg;
    localparam int DATA_W = 8;
    localparam int CNT_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int PKT_W = 10;
    localparam int BURST_W = 5;
    localparam logic [3:0] EP_IDX_MIN = 4'h2;
    localparam logic [3:0] EP_IDX_MAX = 4'hf;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_LAST = 16'h0001;
    localparam int PIN_N = 4;
    localparam int PIN_ACK = 0;
    localparam int PIN_EOT = 1;
    localparam int PIN_RD = 2;
    localparam int PIN_WR = 3;

    typedef struct packed {
        logic short_pkt;
        logic last;
        logic [DATA_W-1:0] data;
    } ude_beat_type;

    typedef struct packed {
        logic ack_only;
        logic counter_eot_en;
        logic short_eot_en;
        logic iso;
        logic burst;
        logic [BURST_W-1:0] burst_len;
        logic [3:0] ep_idx;
        logic dir_in;
        logic [PKT_W-1:0] max_pkt;
    } ude_cfg_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_XFER = 2'b11,
        ST_DONE = 2'b10
    } ude_state_type;

    typedef enum logic [2:0] {
        CAUSE_NONE = 3'h0,
        CAUSE_EXT = 3'h1,
        CAUSE_COUNT = 3'h2,
        CAUSE_SHORT = 3'h3,
        CAUSE_EOP = 3'h4,
        CAUSE_DISABLE = 3'h5
    } ude_cause_type;
endpackage : ude_pkg

// ### verif/ude_dma_ctrl_asserts.sv
// Purpose: Port-level checks for the endpoint DMA transfer control
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound onto every ude_dma_ctrl instance
`timescale 1ns/10ps

module ude_dma_ctrl_chk #(
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire ude_pkg::ude_cfg_type cfg,
    input wire logic dma_enable,
    input wire logic [ude_pkg::CNT_W-1:0] byte_count,
    input wire logic dma_acknowledge,
    input wire logic end_of_transfer,
    input wire logic dma_request,
    input wire logic [3:0] dma_ep_select,
    input wire logic dma_ep_select_valid,
    input wire logic ep_discard,
    input wire logic ep_validate,
    input wire logic term_irq,
    input wire ude_pkg::ude_cause_type term_cause,
    input wire logic dma_active,
    input wire logic [ude_pkg::CNT_W-1:0] count_left
);
    // Set by termination, cleared when enable drops
    logic held_r;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            held_r <= 1'h0;
        end else begin
            held_r <= term_irq || (held_r && dma_enable);
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    chk_irq_cause_real: assert property (term_irq |-> term_cause != ude_pkg::CAUSE_NONE
        && term_cause != ude_pkg::CAUSE_DISABLE) else $error("bad irq cause");
    chk_req_held_low: assert property (held_r |-> !dma_request)
        else $error("late request");
    chk_req_when_active: assert property (dma_request |-> dma_active)
        else $error("idle request");
    chk_start_loads_count: assert property ($rose(dma_enable) && !dma_active
        && cfg.ep_idx >= ude_pkg::EP_IDX_MIN |-> ##[1:3] (dma_active && count_left == byte_count))
        else $error("count not loaded");
    chk_bad_index_ignored: assert property ($rose(dma_enable)
        && cfg.ep_idx < ude_pkg::EP_IDX_MIN |-> ##1 !dma_active [*4])
        else $error("bad index started");
    chk_eot_stops: assert property ($rose(end_of_transfer) && dma_active
        |-> ##[1:6] !dma_active) else $error("eot no stop");
    chk_discard_out_only: assert property (ep_discard |-> !cfg.dir_in
        ##[0:1] term_cause == ude_pkg::CAUSE_EXT) else $error("bad discard");
    chk_validate_in_only: assert property (ep_validate |-> cfg.dir_in)
        else $error("bad validate");
    chk_single_drop: assert property ($fell(dma_acknowledge) && dma_active && !cfg.burst
        |-> ##[1:5] !dma_request) else $error("request held");
    chk_ack_select: assert property (dma_acknowledge [*5] ##0 cfg.ep_idx >= ude_pkg::EP_IDX_MIN
        |-> dma_ep_select_valid && dma_ep_select == cfg.ep_idx) else $error("no select");
endmodule : ude_dma_ctrl_chk

bind ude_dma_ctrl ude_dma_ctrl_chk #(.DEPTH(DEPTH)) chk_u (.clk_sys, .arst_n, .cfg, .dma_enable,
    .byte_count, .dma_acknowledge, .end_of_transfer, .dma_request, .dma_ep_select,
    .dma_ep_select_valid, .ep_discard, .ep_validate, .term_irq, .term_cause, .dma_active,
    .count_left);

// ### verif/ude_dmac_model.sv
// Purpose: Behavioural external DMA controller answering the request pin
// Assumes: Block samples the pins through two flops
// Notes: Unused strobes pulse twice per ack-only beat
`timescale 1ns/10ps

module ude_dmac_model (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic dma_request,
    input wire logic ack_only,
    input wire logic dir_in,
    input wire logic [3:0] slow,
    output logic dma_acknowledge,
    output logic read_strobe,
    output logic write_strobe,
    output logic [7:0] dma_data_in
);
    logic [7:0] next_byte;

    initial begin
        dma_acknowledge = 1'h0;
        read_strobe = 1'h0;
        write_strobe = 1'h0;
        dma_data_in = 8'h5a;
        next_byte = 8'ha0;
        forever begin
            @(posedge clk_sys);
            if (arst_n && dma_request) begin
                dma_data_in <= next_byte;
                dma_acknowledge <= 1'h1;
                // Catches a block that counts strobes
                for (int k = 0; k < (ack_only ? 2 : 1); k++) begin
                    read_strobe <= ack_only || !dir_in;
                    write_strobe <= ack_only || dir_in;
                    repeat (2 + slow) @(posedge clk_sys);
                    read_strobe <= 1'h0;
                    write_strobe <= 1'h0;
                    repeat (2) @(posedge clk_sys);
                end
                dma_acknowledge <= 1'h0;
                repeat (6) @(posedge clk_sys);
                dma_data_in <= ~next_byte;
                if (dir_in) begin
                    next_byte <= next_byte + 8'h01;
                end
            end
        end
    end
endmodule : ude_dmac_model

// ### verif/tb.sv
// Purpose: Self-checking bench for the endpoint DMA transfer control
// Assumes: Partner model answers requests; bench drives the endpoint side
// Notes: Rows for plain transfers, hand tests after
`timescale 1ns/10ps

module tb;
    typedef struct packed {
        logic ack_only, dir_in, short_en, cnt_en, burst;
        logic [15:0] count;
        logic [3:0] fill, moved;
        ude_pkg::ude_cause_type cause;
    } ude_row_type;
    localparam ude_row_type ROWS [6] = '{
        '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 16'h0003, 4'h3, 4'h3, ude_pkg::CAUSE_COUNT},
        '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 16'h0002, 4'h2, 4'h2, ude_pkg::CAUSE_COUNT},
        '{1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 16'h0004, 4'h4, 4'h4, ude_pkg::CAUSE_COUNT},
        '{1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 16'h0002, 4'h4, 4'h4, ude_pkg::CAUSE_SHORT},
        '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 16'h0008, 4'h0, 4'h8, ude_pkg::CAUSE_COUNT},
        '{1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 16'h0003, 4'h0, 4'h3, ude_pkg::CAUSE_SHORT}};
    logic clk_sys, arst_n, dma_enable, end_of_transfer, usb_eop, ep_rx_valid, ep_tx_ready;
    logic dma_acknowledge, read_strobe, write_strobe, dma_data_oe, dma_request, ep_rx_ready;
    logic ep_tx_valid, dma_ep_select_valid, ep_discard, ep_validate, term_irq, dma_active, oe_q;
    logic [7:0] dma_data_in, dma_data_out, pexp;
    logic [15:0] byte_count, count_left;
    logic [3:0] dma_ep_select, slow;
    ude_pkg::ude_cfg_type cfg;
    ude_pkg::ude_beat_type ep_rx_beat, ep_tx_beat;
    ude_pkg::ude_cause_type term_cause;
    int compares, miscompares, irq_n, disc_n, val_n, n0;
    logic [7:0] outq[$];

    ude_dma_ctrl dut_u (.clk_sys, .arst_n, .ce(1'h1), .cfg, .dma_enable, .byte_count,
        .dma_acknowledge, .end_of_transfer, .read_strobe, .write_strobe, .dma_data_in,
        .dma_data_out, .dma_data_oe, .dma_request, .ep_rx_valid, .ep_rx_beat, .ep_rx_ready,
        .ep_tx_valid, .ep_tx_beat, .ep_tx_ready, .usb_eop, .dma_ep_select, .dma_ep_select_valid,
        .ep_discard, .ep_validate, .term_irq, .term_cause, .dma_active, .count_left);
    ude_dmac_model dmac_u (.clk_sys, .arst_n, .dma_request, .ack_only(cfg.ack_only),
        .dir_in(cfg.dir_in), .slow, .dma_acknowledge, .read_strobe, .write_strobe, .dma_data_in);

    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(negedge clk_sys) begin
        if (dma_data_oe && !oe_q) outq.push_back(dma_data_out);
        oe_q = dma_data_oe;
        irq_n += int'(term_irq);
        disc_n += int'(ep_discard);
        val_n += int'(ep_validate);
    end

    task automatic close_out();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic timed_out();
        check(16'h0000, 16'h0001);
        close_out();
    endtask : timed_out

    task automatic wait_until(input int what, input int n);
        for (int k = 0; k < 900; k++) begin
            @(negedge clk_sys);
            if (what == 0 ? term_irq === 1'h1 : outq.size() >= n) return;
        end
        timed_out();
    endtask : wait_until

    // Valid held between beats
    task automatic fill(input logic [3:0] n, input logic sh);
        int k;
        for (int i = 0; i < n; i++) begin
            ep_rx_beat = '{short_pkt: sh && i == n - 1, last: i == n - 1, data: 8'h10 + 8'(i)};
            ep_rx_valid = 1'h1;
            for (k = 0; k < 40 && ep_rx_ready !== 1'h1; k++) @(negedge clk_sys);
            if (k == 40) timed_out();
            @(negedge clk_sys);
        end
        ep_rx_valid = 1'h0;
    endtask : fill

    task automatic drain(input logic [3:0] n, input logic [7:0] base);
        int k;
        ep_tx_ready = 1'h1;
        for (int i = 0; i < n; i++) begin
            for (k = 0; k < 40 && ep_tx_valid !== 1'h1; k++) @(negedge clk_sys);
            if (k == 40) timed_out();
            check(16'(ep_tx_beat.data), 16'(base + 8'(i)));
            @(negedge clk_sys);
        end
        check(16'(ep_tx_valid), 16'h0000);
        ep_tx_ready = 1'h0;
    endtask : drain

    initial begin
        {arst_n, dma_enable, end_of_transfer, usb_eop, ep_rx_valid, ep_tx_ready, oe_q} = '0;
        {compares, miscompares, irq_n, disc_n, val_n} = '0;
        cfg = '0;
        cfg.burst_len = 5'h04;
        cfg.ep_idx = 4'h3;
        cfg.max_pkt = 10'h040;
        {byte_count, slow, pexp, ep_rx_beat} = {16'h0000, 4'h0, 8'ha0, 10'h000};
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'h1;
        check(16'({dma_request, dma_active, term_irq, term_cause}), 16'h0000);
        @(negedge clk_sys);
        foreach (ROWS[i]) begin
            {cfg.ack_only, cfg.dir_in, cfg.short_eot_en, cfg.counter_eot_en, cfg.burst} = ROWS[i][31:27];
            slow = 4'(i);
            outq.delete();
            n0 = val_n;
            fill(ROWS[i].fill, ROWS[i].short_en);
            byte_count = ROWS[i].count;
            dma_enable = 1'h1;
            wait_until(0, 0);
            @(negedge clk_sys);
            check(16'(term_cause), 16'(ROWS[i].cause));
            if (ROWS[i].dir_in) begin
                check(16'(val_n - n0), 16'h0001);
                drain(ROWS[i].moved, pexp);
                pexp = pexp + 8'(ROWS[i].moved);
            end else begin
                check(16'(outq.size()), 16'(ROWS[i].moved));
                foreach (outq[k]) check(16'(outq[k]), 16'h0010 + 16'(k));
            end
            dma_enable = 1'h0;
            repeat (4) @(negedge clk_sys);
            $display("row %0d done", i);
        end
        {cfg.iso, cfg.dir_in, cfg.short_eot_en, cfg.counter_eot_en, cfg.ack_only} = 5'h11;
        dma_enable = 1'h1;
        repeat (5) @(negedge clk_sys);
        usb_eop = 1'h1;
        wait_until(0, 0);
        usb_eop = 1'h0;
        check(16'(term_cause), 16'(ude_pkg::CAUSE_EOP));
        dma_enable = 1'h0;
        {cfg.iso, cfg.counter_eot_en} = 2'h1;
        repeat (4) @(negedge clk_sys);
        $display("eop test done");
        fill(4'h8, 1'h0);
        check(16'(ep_rx_ready), 16'h0000);
        outq.delete();
        n0 = irq_n;
        byte_count = 16'h0008;
        dma_enable = 1'h1;
        wait_until(1, 1);
        dma_enable = 1'h0;
        repeat (8) @(negedge clk_sys);
        check(16'(term_cause), 16'(ude_pkg::CAUSE_DISABLE));
        check(16'({irq_n - n0, dma_active}), 16'h0000);
        $display("disable test done");
        outq.delete();
        n0 = disc_n;
        dma_enable = 1'h1;
        wait_until(1, 1);
        end_of_transfer = 1'h1;
        repeat (2) @(negedge clk_sys);
        end_of_transfer = 1'h0;
        wait_until(0, 0);
        @(negedge clk_sys);
        check(16'(term_cause), 16'(ude_pkg::CAUSE_EXT));
        check(16'(disc_n - n0), 16'h0001);
        dma_enable = 1'h0;
        repeat (4) @(negedge clk_sys);
        dma_enable = 1'h1;
        repeat (30) @(negedge clk_sys);
        check(16'(dma_request), 16'h0000);
        dma_enable = 1'h0;
        cfg.ep_idx = 4'h1;
        fill(4'h1, 1'h0);
        dma_enable = 1'h1;
        repeat (10) @(negedge clk_sys);
        check(16'({dma_active, dma_request}), 16'h0000);
        $display("eot and index tests done");
        close_out();
    end
endmodule : tb
